/* hw/vdff_pkg.sv */
//Behaviour
//- A/D self-check mismatch while tristated sets the A/D flag; reading the register clears it.
//- A logic self-test failure keeps the channel tristated while the fault persists.
//- Logic self-test status sits in exception bits 10:9 and clears on read.
//- Restart after self-test failure: clear diagnostic bits, then set the drive enable bit.
//- Trimming CRC failure selects default trimming and sets service fault bits 18:17.
//- Trimming CRC flag clears only on reset; mask bit 5 forces stored data.
//- Calibration CRC failure loads defaults and sets exception bits 14:13 until reset.
//- Calibration recovery by re-enabling the channel or setting driver mask bits 14:13.
//- Off-state self test failure, tristated, diagnostic off, sets bits 8:7; read clears.
//- Output differing from PWM command while driving sets bits 12:11; read clears.
//- Logic self-test stays idle while its request bit is zero.
//- Registers with failed CRC data are loaded with all zeros.
package vdff_pkg;

   localparam int CH_N   = 2;
   localparam int APB_AW = 8;
   localparam int IRQ_N  = 6;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [APB_AW-1:0] OFS_EXC  = 8'h00;
   localparam logic [APB_AW-1:0] OFS_SVC  = 8'h04;
   localparam logic [APB_AW-1:0] OFS_SMSK = 8'h08;
   localparam logic [APB_AW-1:0] OFS_DMSK = 8'h0c;
   localparam logic [APB_AW-1:0] OFS_DRV  = 8'h10;
   localparam logic [APB_AW-1:0] OFS_CFG  = 8'h14;
   localparam logic [APB_AW-1:0] OFS_IRQS = 8'h18;
   localparam logic [APB_AW-1:0] OFS_IRQM = 8'h1c;

   ////////////////////////////////////////////////////////////////////////
   // Field positions (low bit of each per-channel field; the single trimming bits for the _BIT names)
   localparam int EXC_ADC_LSB   = 0;
   localparam int EXC_OST_LSB   = 7;
   localparam int EXC_BIST_LSB  = 9;
   localparam int EXC_PWM_LSB   = 11;
   localparam int EXC_CRC_LSB   = 13;
   localparam int SVC_TFLG_BIT  = 17;
   localparam int SVC_TDEF_BIT  = 18;
   localparam int SMSK_TRIM_BIT = 5;
   localparam int DMSK_CRC_LSB  = 13;
   localparam int DRV_EN_LSB    = 0;
   localparam int CFG_BIST_LSB  = 0;
   localparam int CFG_OST_LSB   = 2;
   localparam int CFG_ODIAG_LSB = 4;

   // Interrupt status bits
   localparam int IRQ_ADC  = 0;
   localparam int IRQ_BIST = 1;
   localparam int IRQ_OST  = 2;
   localparam int IRQ_PWM  = 3;
   localparam int IRQ_SCRC = 4;
   localparam int IRQ_TCRC = 5;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [CH_N-1:0]  CH_RST   = 2'h0;
   localparam logic [IRQ_N-1:0] IRQ_RST  = 6'h00;
   localparam logic [31:0]      WORD_RST = 32'h0000_0000;

endpackage

/* hw/vdff_cor_flag.sv */
`timescale 1ns/1ps
module vdff_cor_flag #(
   parameter int W = 2
) (
   input  wire logic         i_mclk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_set,
   input  wire logic [W-1:0] i_clr,
   output logic      [W-1:0] o_q
);
   import vdff_pkg::*;

   typedef struct packed {
      logic [W-1:0] q;
   } vdff_cor_t;

   vdff_cor_t s;
   vdff_cor_t n;

   // Only bits that were returned to software are cleared; a set wins
   always_comb begin
      n   = s;
      n.q = (s.q & ~i_clr) | i_set;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign o_q = s.q;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   AST_COR_SET_WINS: assert property (|i_set |=> ((o_q & $past(i_set)) == $past(i_set)))
      else $error("flag set lost");
   AST_COR_HOLD: assert property ((i_set == '0 && i_clr == '0) |=> $stable(o_q))
      else $error("flag changed without cause");

endmodule

/* hw/vdff_fault_flags.sv */
`timescale 1ns/1ps
module vdff_fault_flags #(
   parameter int CAL_W  = 8,
   parameter int TRIM_W = 8
) (
   input  wire logic                               i_mclk,
   input  wire logic                               i_rst,
   input  wire logic                               i_psel,
   input  wire logic                               i_penable,
   input  wire logic                               i_pwrite,
   input  wire logic [vdff_pkg::APB_AW-1:0]        i_paddr,
   input  wire logic [31:0]                        i_pwdata,
   input  wire logic [3:0]                         i_pstrb,
   output logic                                    o_pready,
   output logic [31:0]                             o_prdata,
   output logic                                    o_pslverr,
   input  wire logic [vdff_pkg::CH_N-1:0]          i_adc_mismatch,
   input  wire logic [vdff_pkg::CH_N-1:0]          i_bist_fail,
   input  wire logic [vdff_pkg::CH_N-1:0]          i_ost_fail,
   input  wire logic [vdff_pkg::CH_N-1:0]          i_pwm_mismatch,
   input  wire logic [vdff_pkg::CH_N-1:0]          i_sol_crc_fail,
   input  wire logic                               i_trim_crc_fail,
   input  wire logic [vdff_pkg::CH_N*CAL_W-1:0]    i_cal_data,
   input  wire logic [TRIM_W-1:0]                  i_trim_data,
   output logic [vdff_pkg::CH_N-1:0]               o_drive_on,
   output logic [vdff_pkg::CH_N-1:0]               o_bist_run,
   output logic [vdff_pkg::CH_N-1:0]               o_ost_run,
   output logic [vdff_pkg::CH_N*CAL_W-1:0]         o_cal_data,
   output logic [TRIM_W-1:0]                       o_trim_data,
   output logic                                    o_irq
);
   import vdff_pkg::*;

   typedef struct packed {
      logic [CH_N-1:0]         drv_en;
      logic [CH_N-1:0]         cfg_bist;
      logic [CH_N-1:0]         cfg_ost;
      logic [CH_N-1:0]         cfg_odiag;
      logic                    svc_msk;
      logic [CH_N-1:0]         drv_msk;
      logic [IRQ_N-1:0]        irq_msk;
      logic                    trim_flag;
      logic                    trim_forced;
      logic [CH_N-1:0]         sol_crc;
      logic [CH_N-1:0]         sol_dflt;
      logic [CH_N-1:0]         bist_hold;
      logic [CH_N*CAL_W-1:0]   cal_q;
      logic [TRIM_W-1:0]       trim_q;
      logic [31:0]             prdata;
      logic                    slverr;
      logic                    done;
   } vdff_st_t;

   vdff_st_t         s;
   vdff_st_t         n;

   logic [CH_N-1:0]  tri_ch;
   logic [CH_N-1:0]  adc_set;
   logic [CH_N-1:0]  bist_set;
   logic [CH_N-1:0]  ost_set;
   logic [CH_N-1:0]  pwm_set;
   logic [CH_N-1:0]  adc_q;
   logic [CH_N-1:0]  bist_q;
   logic [CH_N-1:0]  ost_q;
   logic [CH_N-1:0]  pwm_q;
   logic [CH_N-1:0]  adc_clr;
   logic [CH_N-1:0]  bist_clr;
   logic [CH_N-1:0]  ost_clr;
   logic [CH_N-1:0]  pwm_clr;
   logic [IRQ_N-1:0] irq_set;
   logic [IRQ_N-1:0] irq_clr;
   logic [IRQ_N-1:0] irq_q;
   logic             acc;
   logic             fin;
   logic             rd_fin;
   logic             wr_fin;
   logic             exc_rd_fin;
   logic             wr_drv_fin;
   logic             hit;
   logic [31:0]      rd_val;
   logic [31:0]      wr_val;
   logic [CH_N-1:0]  drv_new;
   logic [CH_N-1:0]  rise;
   logic             trim_dflt;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Flag qualification
   assign o_drive_on = s.drv_en & ~s.bist_hold;
   assign tri_ch     = ~o_drive_on;
   assign o_bist_run = s.cfg_bist & tri_ch;
   assign o_ost_run  = s.cfg_ost & ~s.cfg_odiag & tri_ch;
   assign adc_set    = i_adc_mismatch & tri_ch;
   assign bist_set   = i_bist_fail & s.cfg_bist;
   assign ost_set    = i_ost_fail & o_ost_run;
   assign pwm_set    = i_pwm_mismatch & o_drive_on;

   assign acc        = i_psel & i_penable;
   assign fin        = acc & s.done;
   assign rd_fin     = fin & ~i_pwrite;
   assign wr_fin     = fin & i_pwrite & hit;
   assign exc_rd_fin = rd_fin && (i_paddr == OFS_EXC);
   assign wr_drv_fin = wr_fin && (i_paddr == OFS_DRV);

   // Clear only what the completed read returned, so late events survive
   assign adc_clr  = exc_rd_fin ? s.prdata[EXC_ADC_LSB +: CH_N] : CH_RST;
   assign bist_clr = exc_rd_fin ? s.prdata[EXC_BIST_LSB +: CH_N] : CH_RST;
   assign ost_clr  = exc_rd_fin ? s.prdata[EXC_OST_LSB +: CH_N] : CH_RST;
   assign pwm_clr  = exc_rd_fin ? s.prdata[EXC_PWM_LSB +: CH_N] : CH_RST;
   assign irq_clr  = (rd_fin && (i_paddr == OFS_IRQS)) ? s.prdata[IRQ_N-1:0] : IRQ_RST;

   always_comb begin
      irq_set           = IRQ_RST;
      irq_set[IRQ_ADC]  = |adc_set;
      irq_set[IRQ_BIST] = |bist_set;
      irq_set[IRQ_OST]  = |ost_set;
      irq_set[IRQ_PWM]  = |pwm_set;
      irq_set[IRQ_SCRC] = |i_sol_crc_fail;
      irq_set[IRQ_TCRC] = i_trim_crc_fail;
   end

   vdff_cor_flag #(.W(CH_N)) u_adc (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_set  (adc_set),
      .i_clr  (adc_clr),
      .o_q    (adc_q)
   );

   vdff_cor_flag #(.W(CH_N)) u_bist (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_set  (bist_set),
      .i_clr  (bist_clr),
      .o_q    (bist_q)
   );

   vdff_cor_flag #(.W(CH_N)) u_ost (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_set  (ost_set),
      .i_clr  (ost_clr),
      .o_q    (ost_q)
   );

   vdff_cor_flag #(.W(CH_N)) u_pwm (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_set  (pwm_set),
      .i_clr  (pwm_clr),
      .o_q    (pwm_q)
   );

   vdff_cor_flag #(.W(IRQ_N)) u_irq (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_set  (irq_set),
      .i_clr  (irq_clr),
      .o_q    (irq_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register readback and decode
   assign trim_dflt = s.trim_flag & ~(s.trim_forced | s.svc_msk);

   always_comb begin
      rd_val = WORD_RST;
      hit    = 1'b1;
      unique case (i_paddr)
         OFS_EXC: begin
            rd_val[EXC_ADC_LSB +: CH_N]  = adc_q;
            rd_val[EXC_OST_LSB +: CH_N]  = ost_q;
            rd_val[EXC_BIST_LSB +: CH_N] = bist_q;
            rd_val[EXC_PWM_LSB +: CH_N]  = pwm_q;
            rd_val[EXC_CRC_LSB +: CH_N]  = s.sol_crc;
         end
         OFS_SVC: begin
            rd_val[SVC_TFLG_BIT] = s.trim_flag;
            rd_val[SVC_TDEF_BIT] = trim_dflt;
         end
         OFS_SMSK: rd_val[SMSK_TRIM_BIT]            = s.svc_msk;
         OFS_DMSK: rd_val[DMSK_CRC_LSB +: CH_N]     = s.drv_msk;
         OFS_DRV:  rd_val[DRV_EN_LSB +: CH_N]       = s.drv_en;
         OFS_CFG: begin
            rd_val[CFG_BIST_LSB +: CH_N]  = s.cfg_bist;
            rd_val[CFG_OST_LSB +: CH_N]   = s.cfg_ost;
            rd_val[CFG_ODIAG_LSB +: CH_N] = s.cfg_odiag;
         end
         OFS_IRQS: rd_val[IRQ_N-1:0] = irq_q;
         OFS_IRQM: rd_val[IRQ_N-1:0] = s.irq_msk;
         default:  hit = 1'b0;
      endcase
      wr_val  = merge_bytes(rd_val, i_pwdata, i_pstrb);
      drv_new = wr_drv_fin ? wr_val[DRV_EN_LSB +: CH_N] : s.drv_en;
      rise    = drv_new & ~s.drv_en;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      n = s;
      // One wait state so read data leaves a flip-flop
      if (acc && !s.done) begin
         n.done   = 1'b1;
         n.prdata = i_pwrite ? WORD_RST : rd_val;
         n.slverr = ~hit;
      end
      if (fin) begin
         n.done = 1'b0;
      end
      if (wr_fin) begin
         unique case (i_paddr)
            OFS_SMSK: n.svc_msk = wr_val[SMSK_TRIM_BIT];
            OFS_DMSK: n.drv_msk = wr_val[DMSK_CRC_LSB +: CH_N];
            OFS_CFG: begin
               n.cfg_bist  = wr_val[CFG_BIST_LSB +: CH_N];
               n.cfg_ost   = wr_val[CFG_OST_LSB +: CH_N];
               n.cfg_odiag = wr_val[CFG_ODIAG_LSB +: CH_N];
            end
            OFS_IRQM: n.irq_msk = wr_val[IRQ_N-1:0];
            default: ;
         endcase
      end
      n.drv_en = drv_new;
      for (int c = 0; c < CH_N; c++) begin
         // Hold drops only once the fault is gone and its flag was read away
         if (wr_drv_fin && wr_val[DRV_EN_LSB + c] && !i_bist_fail[c] && !bist_q[c]) begin
            n.bist_hold[c] = 1'b0;
         end
         if (bist_set[c]) begin
            n.bist_hold[c] = 1'b1;
         end
         if (rise[c]) begin
            n.sol_dflt[c] = 1'b0;
         end
         if (i_sol_crc_fail[c]) begin
            n.sol_dflt[c] = 1'b1;
            n.sol_crc[c]  = 1'b1;
         end
         n.cal_q[c*CAL_W +: CAL_W] = (s.sol_dflt[c] && !s.drv_msk[c]) ?
                                     '0 : i_cal_data[c*CAL_W +: CAL_W];
      end
      n.trim_flag   = s.trim_flag | i_trim_crc_fail;
      // Once masked while the CRC flag is set, the stored trimming stays in use until reset
      n.trim_forced = s.trim_forced | (s.trim_flag & s.svc_msk);
      n.trim_q      = trim_dflt ? '0 : i_trim_data;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign o_pready    = s.done;
   assign o_prdata    = s.prdata;
   assign o_pslverr   = s.slverr & s.done;
   assign o_cal_data  = s.cal_q;
   assign o_trim_data = s.trim_q;
   assign o_irq       = |(irq_q & s.irq_msk);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   AST_ADC_SET: assert property ((i_adc_mismatch[0] && !o_drive_on[0]) |=> adc_q[0])
      else $error("A/D check flag not set");
   // Self-test checks watch channel 1, the channel the scenarios drive
   AST_BIST_TRI: assert property ((i_bist_fail[1] && s.cfg_bist[1]) ##1 i_bist_fail[1] |=> !o_drive_on[1])
      else $error("channel driven during self-test fault");
   AST_BIST_COR: assert property ((exc_rd_fin && s.prdata[EXC_BIST_LSB + 1] && !bist_set[1]) |=> !bist_q[1])
      else $error("self-test status not cleared by read");
   AST_RESTART: assert property ((s.bist_hold[1] && !(wr_drv_fin && wr_val[DRV_EN_LSB + 1])) |=> s.bist_hold[1])
      else $error("channel released without restart sequence");
   AST_TRIM_DFLT: assert property ((s.trim_flag && !s.trim_forced && !s.svc_msk) |=> o_trim_data == '0)
      else $error("default trimming not applied");
   AST_TRIM_POR: assert property (s.trim_flag |=> (s.trim_flag &&
                                  (!o_pready || i_pwrite || i_paddr != OFS_SVC || o_prdata[SVC_TFLG_BIT])))
      else $error("trimming CRC flag cleared without reset");
   AST_SOL_CRC: assert property ((s.sol_crc[0] || i_sol_crc_fail[0]) |=> s.sol_crc[0])
      else $error("calibration CRC flag lost");
   AST_SOL_RECOV: assert property ((wr_drv_fin && rise[0] && !i_sol_crc_fail[0]) |=> !s.sol_dflt[0])
      else $error("re-enable did not recover calibration");
   AST_OST_SET: assert property ((i_ost_fail[0] && !o_drive_on[0] && s.cfg_ost[0] && !s.cfg_odiag[0]) |=> ost_q[0])
      else $error("off-state self test flag not set");
   AST_PWM_SET: assert property ((i_pwm_mismatch[0] && o_drive_on[0]) |=> pwm_q[0])
      else $error("PWM check flag not set");
   AST_BIST_IDLE: assert property (!s.cfg_bist[1] |-> (!o_bist_run[1] && !bist_set[1]))
      else $error("self-test running without request");
   AST_CAL_ZERO: assert property ((s.sol_dflt[0] && !s.drv_msk[0]) |=> o_cal_data[CAL_W-1:0] == '0)
      else $error("calibration default not zero");
   AST_APB_WAIT: assert property ((acc && !s.done) |=> (o_pready || !i_psel))
      else $error("APB answer late");

   COV_RESTART: cover property (s.bist_hold[1] ##1 !s.bist_hold[1]);
   COV_EXC_CLR: cover property (exc_rd_fin && s.prdata[EXC_PWM_LSB]);
   COV_TRIM_MSK: cover property (s.trim_flag && s.trim_forced);
   COV_IRQ: cover property (o_irq);

endmodule

/* verif/vdff_mcu_model.sv */
`timescale 1ns/1ps
module vdff_mcu_model (
   input  wire logic                        i_mclk,
   input  wire logic                        i_pready,
   input  wire logic [31:0]                 i_prdata,
   input  wire logic                        i_pslverr,
   output logic                             o_psel,
   output logic                             o_penable,
   output logic                             o_pwrite,
   output logic [vdff_pkg::APB_AW-1:0]      o_paddr,
   output logic [31:0]                      o_pwdata,
   output logic [3:0]                       o_pstrb
);
   import vdff_pkg::*;
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = '0;
      o_pwdata = '0;
      o_pstrb = 4'h0;
   end
   // Idle edge first: psel is never driven twice in one step
   task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q, output logic e, output bit ok);
      int n;
      @(posedge i_mclk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      o_pstrb <= s;
      @(posedge i_mclk);
      o_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (i_pready !== 1'b1 && n < 40);
      ok = (i_pready === 1'b1);
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // Released bus must not keep showing the old request
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask
endmodule

/* verif/vdff_fault_flags_bench.sv */
`timescale 1ns/1ps
module vdff_fault_flags_bench;
   import vdff_pkg::*;
   logic              i_mclk = 1'b0;
   logic              i_rst = 1'b1;
   logic              psel, pen, pwr, rdy, serr, irq;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:0]        pstrb;
   logic [CH_N-1:0]   adc = '0, bist = '0, ost = '0, pwm = '0, scrc = '0;
   logic [CH_N-1:0]   drv, brun, orun;
   logic              tcrc = 1'b0;
   logic [15:0]       cal = 16'ha5c3, cal_o;
   logic [7:0]        trim = 8'h3c, trim_o;
   int                err_total = 0;
   int                checks_done = 0;

   always #2.5 i_mclk = ~i_mclk;

   vdff_fault_flags DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(rdy),
      .o_prdata(prdata), .o_pslverr(serr), .i_adc_mismatch(adc), .i_bist_fail(bist),
      .i_ost_fail(ost), .i_pwm_mismatch(pwm), .i_sol_crc_fail(scrc), .i_trim_crc_fail(tcrc),
      .i_cal_data(cal), .i_trim_data(trim), .o_drive_on(drv), .o_bist_run(brun),
      .o_ost_run(orun), .o_cal_data(cal_o), .o_trim_data(trim_o), .o_irq(irq));

   vdff_mcu_model u_mcu (.i_mclk(i_mclk), .i_pready(rdy), .i_prdata(prdata), .i_pslverr(serr),
      .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata),
      .o_pstrb(pstrb));

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      bit   ok;
      logic e;
      u_mcu.xfer(w, a, d, s, q, e, ok);
      if (!ok) begin
         err_total++;
         $display("unexpected at %0t: no answer on the register bus", $time);
         final_report();
      end
      chk({31'h0, e}, {31'h0, a > OFS_IRQM}, "error response");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xf(1'b0, a, '0, 4'h0, q);
      if (a <= OFS_IRQM) begin
         chk(q, exp, "read data");
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic [31:0] q;
      xf(1'b1, a, d, s, q);
   endtask
   task automatic tick();
      @(posedge i_mclk);
   endtask
   // Outputs looked at once the edge's updates have landed
   task automatic settle();
      @(posedge i_mclk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) tick();
      i_rst <= 1'b0;
      for (int a = 0; a <= 32; a += 4) begin
         rd(8'(a), 32'h0);
      end
      // Interrupt raised, read away, then masked
      wr(OFS_IRQM, 32'h3f);
      adc <= 2'b10;
      tick();
      adc <= '0;
      tick();
      settle();
      chk({31'h0, irq}, 32'h1, "irq raised");
      rd(OFS_EXC, 32'h2);
      rd(OFS_EXC, 32'h0);
      rd(OFS_IRQS, 32'h1);
      settle();
      chk({31'h0, irq}, 32'h0, "irq cleared");
      wr(OFS_IRQM, 32'h0);
      adc <= 2'b01;
      tick();
      adc <= '0;
      tick();
      settle();
      chk({31'h0, irq}, 32'h0, "irq masked");
      rd(OFS_IRQS, 32'h1);
      rd(OFS_EXC, 32'h1);
      // Fault still present across a read
      adc <= 2'b01;
      tick();
      rd(OFS_EXC, 32'h1);
      rd(OFS_EXC, 32'h1);
      adc <= '0;
      rd(OFS_EXC, 32'h1);
      rd(OFS_EXC, 32'h0);
      // Logic self-test on channel 1 and restart
      bist <= 2'b10;
      repeat (2) tick();
      rd(OFS_EXC, 32'h0);
      chk({30'h0, brun}, 32'h0, "self-test idle");
      wr(OFS_CFG, 32'h2);
      settle();
      chk({30'h0, brun}, 32'h2, "self-test running");
      wr(OFS_DRV, 32'h3);
      settle();
      chk({30'h0, drv}, 32'h1, "held tristated");
      tick();
      bist <= '0;
      wr(OFS_DRV, 32'h3);
      settle();
      chk({30'h0, drv}, 32'h1, "restart before read");
      rd(OFS_EXC, 32'h400);
      rd(OFS_EXC, 32'h0);
      wr(OFS_DRV, 32'h3);
      settle();
      chk({30'h0, drv}, 32'h3, "restarted");
      wr(OFS_CFG, 32'h0);
      // Output against PWM, only while driving
      pwm <= 2'b01;
      tick();
      pwm <= '0;
      rd(OFS_EXC, 32'h800);
      rd(OFS_EXC, 32'h0);
      wr(OFS_DRV, 32'h2);
      pwm <= 2'b01;
      tick();
      pwm <= '0;
      rd(OFS_EXC, 32'h0);
      // Off-state self test, diagnostic on then off
      wr(OFS_CFG, 32'h14);
      settle();
      chk({30'h0, orun}, 32'h0, "off-state test blocked");
      tick();
      ost <= 2'b01;
      tick();
      ost <= '0;
      rd(OFS_EXC, 32'h0);
      wr(OFS_CFG, 32'h4);
      settle();
      chk({30'h0, orun}, 32'h1, "off-state test running");
      tick();
      ost <= 2'b01;
      tick();
      ost <= '0;
      rd(OFS_EXC, 32'h80);
      rd(OFS_EXC, 32'h0);
      wr(OFS_CFG, 32'h0);
      wr(OFS_DRV, 32'h0, 4'h0);
      rd(OFS_DRV, 32'h2);
      wr(OFS_DRV, 32'h0);
      // Calibration data check on channel 0
      scrc <= 2'b01;
      tick();
      scrc <= '0;
      settle();
      chk({16'h0, cal_o}, 32'ha500, "calibration default");
      rd(OFS_EXC, 32'h2000);
      rd(OFS_EXC, 32'h2000);
      wr(OFS_DMSK, 32'h2000);
      settle();
      chk({16'h0, cal_o}, 32'ha5c3, "calibration masked");
      wr(OFS_DMSK, 32'h0);
      settle();
      chk({16'h0, cal_o}, 32'ha500, "calibration unmasked");
      wr(OFS_DRV, 32'h1);
      settle();
      chk({16'h0, cal_o}, 32'ha5c3, "calibration reloaded");
      rd(OFS_EXC, 32'h2000);
      // Trimming data check
      tcrc <= 1'b1;
      tick();
      tcrc <= 1'b0;
      settle();
      chk({24'h0, trim_o}, 32'h0, "trimming default");
      rd(OFS_SVC, 32'h60000);
      rd(OFS_SVC, 32'h60000);
      wr(OFS_SMSK, 32'h20);
      settle();
      chk({24'h0, trim_o}, 32'h3c, "trimming masked");
      rd(OFS_SVC, 32'h20000);
      rd(OFS_SMSK, 32'h20);
      // Only a reset clears the CRC flags
      i_rst <= 1'b1;
      repeat (2) tick();
      i_rst <= 1'b0;
      rd(OFS_EXC, 32'h0);
      rd(OFS_SVC, 32'h0);
      final_report();
   end
endmodule
